// file: design/rst_seq_pkg.sv
// rst_seq_pkg: constants, register map and types of the reset timeout sequencer
// assumes a 50 MHz core clock and a Wishbone bus with byte addresses

package rst_seq_pkg;

  // timing
  localparam int CLK_HZ           = 50_000_000;
  localparam int PU_TIMER_MS      = 72;          // nominal power-up timeout
  localparam int RC_HZ_DEF        = 1_000_000;   // internal rc oscillator rate
  localparam int OSC_STARTUP_CNT  = 1024;        // oscillator input cycles
  localparam int BROWNOUT_MIN_NS  = 1000;        // brownout_min_duration
  // least time rounds up to whole clock cycles
  localparam int BROWNOUT_MIN_CYC = (BROWNOUT_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

  // register byte addresses
  localparam logic [7:0] ADR_PWR_STATUS = 8'h00;
  localparam logic [7:0] ADR_CFG        = 8'h04;
  localparam logic [7:0] ADR_IRQ_STATUS = 8'h08;
  localparam logic [7:0] ADR_IRQ_CLEAR  = 8'h0c;
  localparam logic [7:0] ADR_IRQ_ENABLE = 8'h10;

  // power status fields
  localparam int POR_FLAG_BIT  = 0;
  localparam int STATE_LSB     = 1;
  localparam int CHIP_RST_BIT  = 4;

  // interrupt events
  localparam int EV_W          = 4;
  localparam int EV_POWER_ON   = 0;
  localparam int EV_BROWNOUT   = 1;
  localparam int EV_RELEASE    = 2;
  localparam int EV_MCLEAR     = 3;

  typedef enum logic [2:0] {
    low_power_crystal_mode  = 3'h0,
    crystal_osc_mode        = 3'h1,
    high_speed_crystal_mode = 3'h2,
    ext_rc_mode             = 3'h3,
    int_rc_mode             = 3'h4,
    ext_clock_mode          = 3'h5
  } osc_mode_t;

  typedef struct packed {
    osc_mode_t osc_mode;
    logic      brownout_enable_cfg;
    logic      powerup_timer_disable_cfg;
  } cfg_t;

  localparam cfg_t CFG_RESET = '{osc_mode: crystal_osc_mode,
                                 brownout_enable_cfg: 1'b1,
                                 powerup_timer_disable_cfg: 1'b0};

  typedef enum logic [2:0] {
    ST_POR_HOLD      = 3'h0,
    ST_BROWNOUT_HOLD = 3'h1,
    ST_PU_TIMER      = 3'h2,
    ST_OSC_START     = 3'h3,
    ST_RUN           = 3'h4
  } seq_state_t;

  // asynchronous inputs, synchronised together
  typedef struct packed {
    logic por_ok;
    logic below;
    logic master_clear_n;
    logic osc_in;
    logic rc_osc;
    logic wake;
  } pin_in_t;

endpackage

// file: design/sync_2ff.sv
// sync_2ff: two flip-flop synchroniser, one chain per bit
// assumes inputs are quasi-static levels or slow clocks relative to clk_i
`timescale 1ns/1ps

module sync_2ff #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i, // core clock
  input  wire logic             rst_i, // synchronous reset
  input  wire logic [WIDTH-1:0] d_i,   // asynchronous input
  output logic      [WIDTH-1:0] q_o    // synchronised output
);

  // first stage feeds only the second stage
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    logic meta;
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        meta   <= 1'b0;
        q_o[i] <= 1'b0;
      end else begin
        meta   <= d_i[i];
        q_o[i] <= meta;
      end
    end
  end

endmodule

// file: design/edge_tick_counter.sv
// edge_tick_counter: counts tick pulses while run_i is high, flags done at LIMIT
// assumes tick_i is a one-cycle pulse on clk_i; dropping run_i re-initialises it
`timescale 1ns/1ps

module edge_tick_counter #(
  parameter int LIMIT = 1024
) (
  input  wire logic clk_i,  // core clock
  input  wire logic rst_i,  // synchronous reset
  input  wire logic run_i,  // count while high
  input  wire logic tick_i, // one-cycle tick
  output logic      done_o  // high once LIMIT ticks seen
);

  localparam int CW = $clog2(LIMIT + 1);

  logic [CW-1:0] cnt;
  wire           last = (cnt == CW'(LIMIT - 1));

  // clearing on run_i low gives a full timeout on every restart
  always_ff @(posedge clk_i) begin
    if (rst_i || !run_i) begin
      cnt    <= '0;
      done_o <= 1'b0;
    end else if (tick_i && !done_o) begin
      cnt    <= cnt + CW'(1);
      done_o <= last;
    end
  end

endmodule

// file: design/reset_timeout_sequencer.sv
// reset_timeout_sequencer: power-on, brownout, power-up timer and oscillator
// start-up sequencing that drives the chip's internal reset
// assumes supply indications, pins and the rc oscillator arrive asynchronously;
// registers sit on a classic Wishbone slave port
//
// Summary of operation
// - from power-on the chip stays in reset until the supply is reported good.
// - loss of the power-on indication alone never resets the running chip.
// - the power-up timer starts only after a power-on or brownout reset.
// - the power-up timer counts rc oscillator ticks and holds reset while counting.
// - the timer-disable config bit skips the power-up timer when set.
// - after the power-up timer, 1024 oscillator input cycles are counted in reset.
// - the start-up count runs only in crystal modes and after power-on or wake-up.
// - the brownout enable config bit turns the brownout reset on when set.
// - a brownout resets the chip only if the supply stays low past the minimum time.
// - a power-on or brownout reset holds until the supply is above the brownout threshold, then times.
// - a brownout during the power-up timer returns to hold and restarts the timer.
// - after power-on the power-up timer precedes the start-up count; a wake-up starts the count directly.
// - the master clear pin gates the reset output, raises an interrupt event on assertion and never restarts timers.
// - the power-on flag clears on power-on and is set only by software.
`timescale 1ns/1ps

module reset_timeout_sequencer #(
  parameter int RC_HZ            = rst_seq_pkg::RC_HZ_DEF,
  parameter int PU_TIMER_TICKS   = rst_seq_pkg::PU_TIMER_MS * (RC_HZ / 1000),
  parameter int OSC_STARTUP_CYC  = rst_seq_pkg::OSC_STARTUP_CNT,
  parameter int BROWNOUT_MIN_CYC = rst_seq_pkg::BROWNOUT_MIN_CYC
) (
  input  wire logic        clk_i,                  // core clock, 50 MHz
  input  wire logic        rst_i,                  // synchronous reset, power-up
  input  wire logic        por_ok_i,               // supply above power-on level
  input  wire logic        below_threshold_i,      // supply below brownout_threshold_voltage
  input  wire logic        master_clear_pin_n_i,   // master_clear_pin, active low
  input  wire logic        oscillator_input_pin_i, // oscillator input
  input  wire logic        rc_osc_i,               // internal rc oscillator
  input  wire logic        wake_i,                 // wake-up from sleep
  input  wire logic        wb_cyc_i,               // bus cycle
  input  wire logic        wb_stb_i,               // bus strobe
  input  wire logic        wb_we_i,                // write enable
  input  wire logic [7:0]  wb_adr_i,               // byte address
  input  wire logic [3:0]  wb_sel_i,               // byte lanes
  input  wire logic [31:0] wb_dat_i,               // write data
  output logic             wb_ack_o,               // acknowledge
  output logic      [31:0] wb_dat_o,               // read data
  output logic             irq_o,                  // level interrupt
  output logic             chip_reset_o            // internal chip reset
);

  localparam int BW = $clog2(BROWNOUT_MIN_CYC + 1);

  rst_seq_pkg::pin_in_t    pins_raw;
  rst_seq_pkg::pin_in_t    pins_s;
  rst_seq_pkg::pin_in_t    pins_prev;
  rst_seq_pkg::cfg_t       cfg;
  rst_seq_pkg::seq_state_t state;
  rst_seq_pkg::seq_state_t next_state;
  logic [BW-1:0]           dip_cnt;
  logic [rst_seq_pkg::EV_W-1:0] irq_stat;
  logic [rst_seq_pkg::EV_W-1:0] irq_en;
  logic [rst_seq_pkg::EV_W-1:0] ev;
  logic                    por_flag;
  logic                    osc_need;
  logic                    pu_done;
  logic                    osc_done;
  logic [31:0]             rd_data;

  assign pins_raw = '{por_ok: por_ok_i, below: below_threshold_i,
                      master_clear_n: master_clear_pin_n_i,
                      osc_in: oscillator_input_pin_i, rc_osc: rc_osc_i,
                      wake: wake_i};

  sync_2ff #(.WIDTH($bits(rst_seq_pkg::pin_in_t))) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (pins_raw),
    .q_o   (pins_s)
  );

  // previous synchronised values for edge detection
  always_ff @(posedge clk_i) begin
    if (rst_i) pins_prev <= '0;
    else       pins_prev <= pins_s;
  end

  // edges and qualified levels
  wire por_rise     = pins_s.por_ok & ~pins_prev.por_ok;
  wire osc_tick     = pins_s.osc_in & ~pins_prev.osc_in;
  wire rc_tick      = pins_s.rc_osc & ~pins_prev.rc_osc;
  wire wake_rise    = pins_s.wake & ~pins_prev.wake;
  wire mclear_act   = ~pins_s.master_clear_n;
  wire mclear_fall  = ~pins_s.master_clear_n & pins_prev.master_clear_n;
  wire below_en     = cfg.brownout_enable_cfg & pins_s.below;
  wire dip_trip     = below_en && (dip_cnt == BW'(BROWNOUT_MIN_CYC));
  wire crystal_sel  = (cfg.osc_mode == rst_seq_pkg::low_power_crystal_mode) ||
                      (cfg.osc_mode == rst_seq_pkg::crystal_osc_mode) ||
                      (cfg.osc_mode == rst_seq_pkg::high_speed_crystal_mode);
  wire in_por_hold  = (state == rst_seq_pkg::ST_POR_HOLD);
  wire por_event    = in_por_hold ? pins_s.por_ok : por_rise;

  // brownout filter: short dips restart the count and never trip
  always_ff @(posedge clk_i) begin
    if (rst_i || !below_en) dip_cnt <= '0;
    else if (!dip_trip)     dip_cnt <= dip_cnt + BW'(1);
  end

  // power-up timer counts rc oscillator ticks
  edge_tick_counter #(.LIMIT(PU_TIMER_TICKS)) u_pu_timer (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .run_i  (state == rst_seq_pkg::ST_PU_TIMER),
    .tick_i (rc_tick),
    .done_o (pu_done)
  );

  // oscillator start-up counts oscillator input cycles
  edge_tick_counter #(.LIMIT(OSC_STARTUP_CYC)) u_osc_start (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .run_i  (state == rst_seq_pkg::ST_OSC_START),
    .tick_i (osc_tick),
    .done_o (osc_done)
  );

  // where the sequence goes after the timers; start-up count needs a crystal
  wire start_osc = osc_need & crystal_sel;
  wire rst_seq_pkg::seq_state_t after_pu =
    start_osc ? rst_seq_pkg::ST_OSC_START : rst_seq_pkg::ST_RUN;

  // sequence state; master clear is not an input here, so it restarts nothing
  always_comb begin
    next_state = state;
    case (state)
      rst_seq_pkg::ST_POR_HOLD: begin
        if (pins_s.por_ok) next_state = rst_seq_pkg::ST_BROWNOUT_HOLD;
      end
      rst_seq_pkg::ST_BROWNOUT_HOLD: begin
        if (!below_en) begin
          if (cfg.powerup_timer_disable_cfg) next_state = after_pu;
          else next_state = rst_seq_pkg::ST_PU_TIMER;
        end
      end
      rst_seq_pkg::ST_PU_TIMER: begin
        if (below_en)     next_state = rst_seq_pkg::ST_BROWNOUT_HOLD;
        else if (pu_done) next_state = after_pu;
      end
      rst_seq_pkg::ST_OSC_START: begin
        if (dip_trip)      next_state = rst_seq_pkg::ST_BROWNOUT_HOLD;
        else if (osc_done) next_state = rst_seq_pkg::ST_RUN;
      end
      rst_seq_pkg::ST_RUN: begin
        // falling power-on indication alone is ignored here
        if (dip_trip)                    next_state = rst_seq_pkg::ST_BROWNOUT_HOLD;
        else if (wake_rise && crystal_sel) next_state = rst_seq_pkg::ST_OSC_START;
      end
      default: next_state = rst_seq_pkg::ST_POR_HOLD;
    endcase
    if (!in_por_hold && por_rise) next_state = rst_seq_pkg::ST_BROWNOUT_HOLD;
  end

  wire next_chip_reset = (next_state != rst_seq_pkg::ST_RUN) | mclear_act;

  // interrupt events
  always_comb begin
    ev = '0;
    ev[rst_seq_pkg::EV_POWER_ON] = por_event;
    ev[rst_seq_pkg::EV_BROWNOUT] = dip_trip &&
                                   (next_state == rst_seq_pkg::ST_BROWNOUT_HOLD) &&
                                   (state != rst_seq_pkg::ST_BROWNOUT_HOLD);
    ev[rst_seq_pkg::EV_RELEASE]  = chip_reset_o & ~next_chip_reset;
    ev[rst_seq_pkg::EV_MCLEAR]   = mclear_fall;
  end

  // sequencer registers; reset output released only on a clock edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state        <= rst_seq_pkg::ST_POR_HOLD;
      osc_need     <= 1'b1;
      chip_reset_o <= 1'b1;
    end else begin
      state        <= next_state;
      chip_reset_o <= next_chip_reset;
      if (por_event || wake_rise) osc_need <= 1'b1;
      else if (next_state == rst_seq_pkg::ST_RUN) osc_need <= 1'b0;
    end
  end

  // bus decode; a write lands on the edge where ack is sampled high
  wire req      = wb_cyc_i & wb_stb_i;
  wire wr_en    = req & wb_ack_o & wb_we_i & wb_sel_i[0];
  wire hit_stat = (wb_adr_i == rst_seq_pkg::ADR_PWR_STATUS);
  wire hit_cfg  = (wb_adr_i == rst_seq_pkg::ADR_CFG);
  wire hit_ist  = (wb_adr_i == rst_seq_pkg::ADR_IRQ_STATUS);
  wire hit_iclr = (wb_adr_i == rst_seq_pkg::ADR_IRQ_CLEAR);
  wire hit_ien  = (wb_adr_i == rst_seq_pkg::ADR_IRQ_ENABLE);
  wire [rst_seq_pkg::EV_W-1:0] clr_mask =
    (wr_en && hit_iclr) ? wb_dat_i[rst_seq_pkg::EV_W-1:0] : '0;

  // read mux; clear register and unmapped addresses read zero
  always_comb begin
    rd_data = '0;
    if (hit_stat) begin
      rd_data[rst_seq_pkg::POR_FLAG_BIT] = por_flag;
      rd_data[rst_seq_pkg::STATE_LSB +: $bits(rst_seq_pkg::seq_state_t)] = state;
      rd_data[rst_seq_pkg::CHIP_RST_BIT] = chip_reset_o;
    end else if (hit_cfg) begin
      rd_data[$bits(rst_seq_pkg::cfg_t)-1:0] = cfg;
    end else if (hit_ist) begin
      rd_data[rst_seq_pkg::EV_W-1:0] = irq_stat;
    end else if (hit_ien) begin
      rd_data[rst_seq_pkg::EV_W-1:0] = irq_en;
    end
  end

  // bus handshake: one wait cycle, ack is a single-cycle pulse
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= req & ~wb_ack_o;
      wb_dat_o <= rd_data;
    end
  end

  // any enabled status bit raises the interrupt on the next edge
  wire irq_pend = |(irq_stat & irq_en);

  // software registers; hardware set wins over a clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg      <= rst_seq_pkg::CFG_RESET;
      irq_en   <= '0;
      irq_stat <= '0;
      irq_o    <= 1'b0;
      por_flag <= 1'b0;
    end else begin
      irq_stat <= (irq_stat & ~clr_mask) | ev;
      irq_o    <= irq_pend;
      if (wr_en && hit_cfg)
        cfg <= rst_seq_pkg::cfg_t'(wb_dat_i[$bits(rst_seq_pkg::cfg_t)-1:0]);
      if (wr_en && hit_ien) irq_en <= wb_dat_i[rst_seq_pkg::EV_W-1:0];
      // power-on forces the flag low, other resets leave it alone
      if (por_event) por_flag <= 1'b0;
      else if (wr_en && hit_stat && wb_dat_i[rst_seq_pkg::POR_FLAG_BIT]) por_flag <= 1'b1;
    end
  end

  // checks on the sequence and the bus
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence req_new_s;   req && !wb_ack_o; endsequence
  sequence ack_pulse_s; wb_ack_o ##1 !wb_ack_o; endsequence
  sequence pu_drop_s;   state == rst_seq_pkg::ST_PU_TIMER && below_en; endsequence

  bus_ack_a: assert property (req_new_s |=> ack_pulse_s)
    else $error("bus ack not a single pulse one cycle after request");
  por_hold_a: assert property (in_por_hold && !pins_s.por_ok |=> in_por_hold ##1 chip_reset_o)
    else $error("left power-on hold without good supply");
  por_fall_a: assert property (state == rst_seq_pkg::ST_RUN && !pins_s.por_ok && !dip_trip && !wake_rise
                               |=> state == rst_seq_pkg::ST_RUN)
    else $error("falling power-on indication reset the chip");
  pu_entry_a: assert property (state == rst_seq_pkg::ST_PU_TIMER |->
                               $past(state) inside {rst_seq_pkg::ST_BROWNOUT_HOLD, rst_seq_pkg::ST_PU_TIMER})
    else $error("power-up timer started from a wrong source");
  pu_skip_a: assert property (state == rst_seq_pkg::ST_BROWNOUT_HOLD && !below_en &&
                              cfg.powerup_timer_disable_cfg |=> state != rst_seq_pkg::ST_PU_TIMER)
    else $error("disabled power-up timer still ran");
  osc_mode_a: assert property (state == rst_seq_pkg::ST_OSC_START |-> crystal_sel &&
                               $past(state) != rst_seq_pkg::ST_BROWNOUT_HOLD || $past(start_osc))
    else $error("start-up count outside crystal mode");
  osc_hold_a: assert property (state == rst_seq_pkg::ST_OSC_START && !osc_done && !dip_trip && !por_rise
                               |=> state == rst_seq_pkg::ST_OSC_START ##0 chip_reset_o)
    else $error("start-up count left early");
  dip_off_a: assert property (!cfg.brownout_enable_cfg && state == rst_seq_pkg::ST_RUN && !por_rise
                              |=> state != rst_seq_pkg::ST_BROWNOUT_HOLD)
    else $error("brownout reset while disabled");
  dip_filter_a: assert property ((state == rst_seq_pkg::ST_RUN && !por_rise)
                                 ##1 state == rst_seq_pkg::ST_BROWNOUT_HOLD |-> $past(dip_trip))
    else $error("brownout reset without minimum duration");
  dip_wait_a: assert property (state == rst_seq_pkg::ST_BROWNOUT_HOLD && below_en
                               |=> state == rst_seq_pkg::ST_BROWNOUT_HOLD && chip_reset_o)
    else $error("left brownout hold while supply low");
  pu_restart_a: assert property (pu_drop_s |=> state == rst_seq_pkg::ST_BROWNOUT_HOLD ##2 !pu_done)
    else $error("power-up timer not reinitialised on brownout");
  mclear_a: assert property (mclear_act && state == rst_seq_pkg::ST_PU_TIMER && !below_en && !pu_done
                             && !por_rise |=> state == rst_seq_pkg::ST_PU_TIMER ##0 chip_reset_o)
    else $error("master clear disturbed the timers");
  por_flag_a: assert property (por_event |=> !por_flag)
    else $error("power-on flag not cleared by power-on");
  rst_or_a: assert property (state != rst_seq_pkg::ST_RUN || $past(mclear_act) |-> chip_reset_o)
    else $error("reset output dropped while a hold is active");
  irq_level_a: assert property (##1 irq_o == $past(irq_pend))
    else $error("interrupt output does not follow enabled status");

endmodule

// file: dv/reset_timeout_sequencer_tb.sv
// reset_timeout_sequencer_tb: scenario bench for the reset timeout sequencer
// assumes shortened counts (20 rc ticks, 8 oscillator edges, 4-cycle brownout filter)
`timescale 1ns/1ps

module reset_timeout_sequencer_tb;
  logic        clk_i, rst_i, por_ok, below, master_clear_pin_n, osc, rc, wake;
  logic        cyc, stb, we, ack, irq, chip_rst;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat, d;
  logic [2:0]  div;
  int          n_mismatch, n_checks, ticks;

  reset_timeout_sequencer #(
    .PU_TIMER_TICKS(20), .OSC_STARTUP_CYC(8), .BROWNOUT_MIN_CYC(4)
  ) u_reset_timeout_sequencer (
    .clk_i(clk_i), .rst_i(rst_i), .por_ok_i(por_ok), .below_threshold_i(below),
    .master_clear_pin_n_i(master_clear_pin_n), .oscillator_input_pin_i(osc), .rc_osc_i(rc), .wake_i(wake),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_ack_o(ack), .wb_dat_o(rdat), .irq_o(irq), .chip_reset_o(chip_rst)
  );

  // 50 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // rc period 8 clocks keeps it under clk/4; oscillator period 4 clocks
  always @(posedge clk_i) begin
    div <= div + 3'h1;
    if (div[1:0] == 2'h3) rc <= ~rc;
    if (div[0]) osc <= ~osc;
  end

  // hang guard, far above the few thousand cycles the scenarios need
  always @(posedge clk_i) begin
    ticks++;
    if (ticks == 10000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  // one classic cycle; ack is sampled at the edge, release follows it
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= v;
    sel  <= 4'hf;
    do @(posedge clk_i); while (ack !== 1'b1);
    d = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(d, exp);
  endtask

  // cycles until chip reset reaches lvl must fall in lo..hi
  task automatic wait_rst(input logic lvl, input int lo, input int hi);
    int n;
    n = 0;
    while (chip_rst !== lvl && n < 2000) begin
      @(posedge clk_i);
      n++;
    end
    n_checks++;
    if (n < lo || n > hi) begin
      n_mismatch++;
      $display("mismatch at %0t: took %0h cycles, expected %0h..%0h", $time, n, lo, hi);
    end
  endtask

  // chip reset must hold lvl for n cycles
  task automatic stays(input logic lvl, input int n);
    logic bad;
    bad = 1'b0;
    repeat (n) begin
      @(posedge clk_i);
      if (chip_rst !== lvl) bad = 1'b1;
    end
    chk({31'h0, bad}, 32'h0);
  endtask

  task automatic pulse_below(input int n);
    @(posedge clk_i) below <= 1'b1;
    repeat (n) @(posedge clk_i);
    below <= 1'b0;
  endtask

  task automatic t_regs();
    rd_chk(8'h04, 32'h06);
    rd_chk(8'h00, 32'h10);
    wb(1'b1, 8'h14, 32'hff);
    rd_chk(8'h14, 32'h0);
    rd_chk(8'h0c, 32'h0);
    stays(1'b1, 100);
  endtask

  task automatic t_power_up();
    @(posedge clk_i) por_ok <= 1'b1;
    wait_rst(1'b0, 180, 235);
    rd_chk(8'h00, 32'h08);
    rd_chk(8'h08, 32'h05);
  endtask

  task automatic t_irq();
    chk({31'h0, irq}, 32'h0);
    wb(1'b1, 8'h10, 32'h4);
    repeat (2) @(posedge clk_i); // irq_o lags the write by one registered stage
    chk({31'h0, irq}, 32'h1);
    wb(1'b1, 8'h0c, 32'h4);
    repeat (2) @(posedge clk_i);
    chk({31'h0, irq}, 32'h0);
    rd_chk(8'h08, 32'h01);
    wb(1'b1, 8'h0c, 32'h1);
    wb(1'b1, 8'h10, 32'h0);
  endtask

  task automatic t_brownout();
    wb(1'b1, 8'h00, 32'h1);
    pulse_below(3);
    stays(1'b0, 20);
    @(posedge clk_i) below <= 1'b1;
    wait_rst(1'b1, 5, 12);
    repeat (40) @(posedge clk_i);
    rd_chk(8'h00, 32'h13);
    below <= 1'b0;
    repeat (80) @(posedge clk_i);
    below <= 1'b1;
    repeat (20) @(posedge clk_i);
    rd_chk(8'h00, 32'h13);
    below <= 1'b0;
    wait_rst(1'b0, 145, 190);
    rd_chk(8'h08, 32'h06);
    wb(1'b1, 8'h0c, 32'hf);
  endtask

  task automatic t_cfg();
    wb(1'b1, 8'h04, 32'h04);
    pulse_below(30);
    stays(1'b0, 30);
    wb(1'b1, 8'h04, 32'h0f);
    rd_chk(8'h04, 32'h0f);
    @(posedge clk_i) below <= 1'b1;
    wait_rst(1'b1, 5, 12);
    below <= 1'b0;
    wait_rst(1'b0, 0, 12);
  endtask

  task automatic t_wake();
    @(posedge clk_i) wake <= 1'b1;
    repeat (3) @(posedge clk_i);
    wake <= 1'b0;
    stays(1'b0, 30);
    // low-power, plain and high-speed crystal in turn; timer stays on with brownout
    for (int m = 0; m < 3; m++) begin
      wb(1'b1, 8'h04, 32'h02 + 32'(m) * 32'h04);
      @(posedge clk_i) wake <= 1'b1;
      wait_rst(1'b1, 2, 8);
      wake <= 1'b0;
      wait_rst(1'b0, 22, 45);
    end
  endtask

  task automatic t_master_clear();
    wb(1'b1, 8'h0c, 32'hf);
    @(posedge clk_i) master_clear_pin_n <= 1'b0;
    wait_rst(1'b1, 2, 6);
    stays(1'b1, 300);
    master_clear_pin_n <= 1'b1;
    wait_rst(1'b0, 2, 6);
    wb(1'b0, 8'h08, 32'h0);
    chk(d & 32'h8, 32'h8);
  endtask

  task automatic t_por_drop();
    @(posedge clk_i) por_ok <= 1'b0;
    stays(1'b0, 50);
    master_clear_pin_n <= 1'b0;
    por_ok <= 1'b1;
    wait_rst(1'b1, 2, 6);
    stays(1'b1, 400);
    master_clear_pin_n <= 1'b1;
    wait_rst(1'b0, 2, 6);
    rd_chk(8'h00, 32'h08);
  endtask

  // reset for 8 cycles, then the scenarios in order
  initial begin
    {por_ok, below, osc, rc, wake, cyc, stb, we} = 8'h00;
    {adr, sel, wdat, div} = '0;
    master_clear_pin_n = 1'b1;
    rst_i = 1'b1;
    n_mismatch = 0;
    n_checks = 0;
    ticks = 0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_power_up();
    t_irq();
    t_brownout();
    t_cfg();
    t_wake();
    t_master_clear();
    t_por_drop();
    wrap_up();
  end
endmodule
